// File: hw/rtca_pkg.sv
// Constants for the alarm compare block: register map, field
// layout, reset values and the time-hold states.
// Assumes a byte-wide register port from the serial engine.
package rtca_pkg;

  ////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] ADDR_MIN_TGT = 8'h0a;
  localparam logic [7:0] ADDR_HOUR_TGT = 8'h0b;
  localparam logic [7:0] ADDR_DATE_TGT = 8'h0c;
  localparam logic [7:0] ADDR_DOW_TGT = 8'h0d;
  localparam logic [7:0] ADDR_EVT_FLAG = 8'h0f;

  ////////////////////////////////////////////////////////////////
  // Writable bits; unused bits store and read as zero
  localparam logic [7:0] MASK_MIN_TGT = 8'hff;
  localparam logic [7:0] MASK_HOUR_TGT = 8'hbf;
  localparam logic [7:0] MASK_DATE_TGT = 8'hbf;
  localparam logic [7:0] MASK_DOW_TGT = 8'h87;

  // Reset values: every compare disabled, no flags pending
  localparam logic [7:0] RST_TGT = 8'h80;
  localparam logic [7:0] RST_EVT = 8'h00;

  ////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_CMP_DIS = 7;
  localparam int BIT_PM = 5;
  localparam int BIT_WDOG = 7;
  localparam int BIT_CDA = 6;
  localparam int BIT_CDB = 5;
  localparam int BIT_SEC = 4;
  localparam int BIT_ALARM = 3;
  localparam int EVT_CTRL_W = 3;

  // Largest legal BCD digits
  localparam logic [3:0] UNITS_MAX = 4'h9;
  localparam logic [3:0] MIN_TENS_MAX = 4'h5;
  localparam logic [3:0] HR12_TENS_MAX = 4'h1;
  localparam logic [3:0] HR24_TENS_MAX = 4'h2;
  localparam logic [3:0] DATE_TENS_MAX = 4'h3;
  localparam logic [2:0] DOW_MAX = 3'h6;

  typedef enum logic [1:0] {TH_RUN, TH_HOLD, TH_PEND} rtca_hold_t;

endpackage

// File: hw/rtca_cmp_if.sv
// Carries alarm targets and the running calendar to the compare
// module and its match result back. Used only inside the block.
interface rtca_cmp_if;
  logic [7:0] min_tgt;
  logic [7:0] hour_tgt;
  logic [7:0] date_tgt;
  logic [7:0] dow_tgt;
  logic [6:0] cur_min;
  logic [5:0] cur_hour;
  logic [5:0] cur_date;
  logic [2:0] cur_dow;
  logic hour_mode_12;
  logic match_all;

  modport ctrl (
    output min_tgt, hour_tgt, date_tgt, dow_tgt,
    output cur_min, cur_hour, cur_date, cur_dow, hour_mode_12,
    input match_all
  );
  modport cmp (
    input min_tgt, hour_tgt, date_tgt, dow_tgt,
    input cur_min, cur_hour, cur_date, cur_dow, hour_mode_12,
    output match_all
  );
endinterface

// File: hw/rtca_match.sv
// Combinational compare of the alarm targets with the calendar.
// Assumes the calendar inputs are stable BCD from the counters.
module rtca_match
  import rtca_pkg::*;
(
  // Targets and calendar in, match out
  rtca_cmp_if.cmp cmp
);

  function automatic logic dig_ok(input logic [3:0] d,
                                  input logic [3:0] dmax);
    dig_ok = (d <= dmax);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Enables are active low
  wire en_min = ~cmp.min_tgt[BIT_CMP_DIS];
  wire en_hour = ~cmp.hour_tgt[BIT_CMP_DIS];
  wire en_date = ~cmp.date_tgt[BIT_CMP_DIS];
  wire en_dow = ~cmp.dow_tgt[BIT_CMP_DIS];

  // An enabled target holding an illegal code never matches
  wire ok_min = dig_ok({1'b0, cmp.min_tgt[6:4]}, MIN_TENS_MAX)
    & dig_ok(cmp.min_tgt[3:0], UNITS_MAX);
  wire ok_hr12 = dig_ok({3'b000, cmp.hour_tgt[4]}, HR12_TENS_MAX);
  wire ok_hr24 = dig_ok({2'b00, cmp.hour_tgt[5:4]}, HR24_TENS_MAX);
  wire ok_hour = (cmp.hour_mode_12 ? ok_hr12 : ok_hr24)
    & dig_ok(cmp.hour_tgt[3:0], UNITS_MAX);
  wire ok_date = dig_ok({2'b00, cmp.date_tgt[5:4]}, DATE_TENS_MAX)
    & dig_ok(cmp.date_tgt[3:0], UNITS_MAX);
  wire ok_dow = (cmp.dow_tgt[2:0] <= DOW_MAX);

  // Bits 5:4 hold PM flag and tens (12-hour) or tens (24-hour); compared whole in both
  wire hit_min = ok_min & (cmp.min_tgt[6:0] == cmp.cur_min);
  wire hit_hour = ok_hour & (cmp.hour_tgt[5:0] == cmp.cur_hour);
  wire hit_date = ok_date & (cmp.date_tgt[5:0] == cmp.cur_date);
  wire hit_dow = ok_dow & (cmp.dow_tgt[2:0] == cmp.cur_dow);

  wire any_en = en_min | en_hour | en_date | en_dow;
  assign cmp.match_all = any_en
    & (~en_min | hit_min) & (~en_hour | hit_hour)
    & (~en_date | hit_date) & (~en_dow | hit_dow);

endmodule

// File: hw/rtca_alarm.sv
// Alarm section of the real-time clock: target registers, match
// edge detect, event-flag register, interrupt pin, time hold.
// Assumes a serial engine on clk_sys gives byte strobes, and the
// calendar counters and flag sources are on the same clock.
//
// Notes on behaviour
// - Alarm targets at four consecutive byte addresses
// - Minute target: low-active enable, BCD minutes
// - Hour target: low-active enable, bit 6 unused
// - Hour mode selects 12-hour or 24-hour layout
// - Date target: enable, bit 6 unused, BCD
// - Weekday target: enable, value 0 to 6
// - All enabled fields matching first sets flag
// - Disabled fields take no part in matching
// - Alarm flag sticky until host clears it
// - Persisting match does not set flag again
// - Flag writes AND into each flag bit
// - Flag layout: wdog, cntA, cntB, sec, alarm
// - Rewriting low control bits changes nothing
// - Interrupt pin follows flag while enabled
// - Clearing flag drops interrupt at once
// - Alarm interrupt is a level, never pulse
// - Hold time during access, keep one tick
module rtca_alarm
  import rtca_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port from the serial engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Bits of the first control register
  input wire logic hour_mode_12,
  input wire logic alarm_irq_enable,
  // Running calendar
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_date,
  input wire logic [2:0] cur_dow,
  // Time-base hold around serial access
  input wire logic sec_tick,
  input wire logic time_access,
  output logic time_inc,
  // Set pulses of the other event flags
  input wire logic watchdog_expired_set,
  input wire logic countdown_a_set,
  input wire logic countdown_b_set,
  input wire logic second_tick_set,
  // Event-flag view
  output logic alarm_flag,
  output logic [2:0] flag_ctrl_bits,
  // Open-drain interrupt pin, driven low when asserted
  output logic irq_out_pin_o,
  output logic irq_out_pin_oe
);

  ////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] min_tgt_ff, hour_tgt_ff, date_tgt_ff, dow_tgt_ff;
  logic [7:0] evt_ff, rdata_ff;
  logic match_q_ff, time_inc_ff;
  rtca_hold_t hold_ff, nxt_hold;
  logic nxt_inc;

  function automatic logic [7:0] merge(input logic [7:0] v,
                                       input logic [7:0] m);
    merge = v & m;
  endfunction

  // Address decode
  wire sel_min = (reg_addr == ADDR_MIN_TGT);
  wire sel_hour = (reg_addr == ADDR_HOUR_TGT);
  wire sel_date = (reg_addr == ADDR_DATE_TGT);
  wire sel_dow = (reg_addr == ADDR_DOW_TGT);
  wire sel_evt = (reg_addr == ADDR_EVT_FLAG);
  wire wr_min = reg_wr & sel_min;
  wire wr_hour = reg_wr & sel_hour;
  wire wr_date = reg_wr & sel_date;
  wire wr_dow = reg_wr & sel_dow;
  wire wr_evt = reg_wr & sel_evt;

  ////////////////////////////////////////////////////////////////
  // Target registers; unused bits are masked on write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      min_tgt_ff <= RST_TGT;
      hour_tgt_ff <= RST_TGT;
      date_tgt_ff <= RST_TGT;
      dow_tgt_ff <= RST_TGT;
    end else begin
      if (wr_min) min_tgt_ff <= merge(reg_wdata, MASK_MIN_TGT);
      if (wr_hour) hour_tgt_ff <= merge(reg_wdata, MASK_HOUR_TGT);
      if (wr_date) date_tgt_ff <= merge(reg_wdata, MASK_DATE_TGT);
      if (wr_dow) dow_tgt_ff <= merge(reg_wdata, MASK_DOW_TGT);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Compare
  rtca_cmp_if u_cmp_if ();
  assign u_cmp_if.min_tgt = min_tgt_ff;
  assign u_cmp_if.hour_tgt = hour_tgt_ff;
  assign u_cmp_if.date_tgt = date_tgt_ff;
  assign u_cmp_if.dow_tgt = dow_tgt_ff;
  assign u_cmp_if.cur_min = cur_min;
  assign u_cmp_if.cur_hour = cur_hour;
  assign u_cmp_if.cur_date = cur_date;
  assign u_cmp_if.cur_dow = cur_dow;
  assign u_cmp_if.hour_mode_12 = hour_mode_12;

  rtca_match u_match (
    .cmp (u_cmp_if.cmp)
  );

  wire match_all = u_cmp_if.match_all;
  // Only the rising edge sets the flag, so a match that lasts a
  // whole minute is not re-raised after the host clears it
  wire alarm_set = match_all & ~match_q_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) match_q_ff <= 1'b0;
    else match_q_ff <= match_all;
  end

  ////////////////////////////////////////////////////////////////
  // Event-flag register
  wire [4:0] flag_set = {watchdog_expired_set, countdown_a_set,
    countdown_b_set, second_tick_set, alarm_set};
  wire [4:0] flag_keep = wr_evt ? (evt_ff[7:3] & reg_wdata[7:3])
    : evt_ff[7:3];
  // Set beats a clearing write in the same cycle
  wire [4:0] nxt_flags = flag_keep | flag_set;
  wire [2:0] nxt_ctrl = wr_evt ? reg_wdata[2:0]
    : evt_ff[2:0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) evt_ff <= RST_EVT;
    else evt_ff <= {nxt_flags, nxt_ctrl};
  end

  assign alarm_flag = evt_ff[BIT_ALARM];
  assign flag_ctrl_bits = evt_ff[EVT_CTRL_W-1:0];

  ////////////////////////////////////////////////////////////////
  // Read path, answer one cycle after the strobe
  wire [7:0] rd_mux = sel_min ? min_tgt_ff
    : sel_hour ? hour_tgt_ff
    : sel_date ? date_tgt_ff
    : sel_dow ? dow_tgt_ff
    : sel_evt ? evt_ff
    : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rdata_ff <= 8'h00;
    else if (reg_rd) rdata_ff <= rd_mux;
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////
  // Interrupt pin; a plain level, no pulse mode exists
  assign irq_out_pin_o = 1'b0;
  assign irq_out_pin_oe = alarm_irq_enable
    & evt_ff[BIT_ALARM];

  ////////////////////////////////////////////////////////////////
  // Time-base hold: only one tick can wait, so an access must
  // finish within a second or a tick is lost
  always_comb begin
    nxt_hold = hold_ff;
    nxt_inc = 1'b0;
    case (hold_ff)
      TH_RUN: begin
        if (time_access) nxt_hold = sec_tick ? TH_PEND : TH_HOLD;
        else nxt_inc = sec_tick;
      end
      TH_HOLD: begin
        if (!time_access) begin
          nxt_hold = TH_RUN;
          nxt_inc = sec_tick;
        end else if (sec_tick) begin
          nxt_hold = TH_PEND;
        end
      end
      TH_PEND: begin
        if (!time_access) begin
          nxt_hold = TH_RUN;
          nxt_inc = 1'b1;
        end
      end
      default: nxt_hold = TH_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= TH_RUN;
      time_inc_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      time_inc_ff <= nxt_inc;
    end
  end

  assign time_inc = time_inc_ff;

  ////////////////////////////////////////////////////////////////
  // Assertions
  AST_MAP_READ: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    reg_rd && reg_addr == ADDR_DOW_TGT |=> reg_rdata == dow_tgt_ff)
    else $error("weekday target not read at its address");

  AST_ALARM_SET: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    match_all && !match_q_ff |=> alarm_flag)
    else $error("first match did not set the alarm flag");

  AST_STICKY: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    alarm_flag && !wr_evt ##1 !wr_evt |=> alarm_flag)
    else $error("alarm flag dropped without a clearing write");

  AST_NO_RESET: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !alarm_flag && match_q_ff && match_all |=> !alarm_flag)
    else $error("lasting match set the alarm flag again");

  AST_AND_WRITE: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    wr_evt |=> evt_ff[7:3] == (($past(evt_ff[7:3])
      & $past(reg_wdata[7:3])) | $past(flag_set)))
    else $error("flag write did not act as AND");

  AST_OTHERS_KEPT: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    wr_evt && reg_wdata[7:4] == 4'hf && evt_ff[BIT_WDOG]
    |=> evt_ff[BIT_WDOG])
    else $error("clearing alarm disturbed the watchdog flag");

  AST_CTRL_SAME: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    wr_evt && reg_wdata[2:0] == evt_ff[2:0]
    |=> $stable(flag_ctrl_bits))
    else $error("rewriting control bits changed them");

  AST_IRQ_ON: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    alarm_set |=> irq_out_pin_oe == alarm_irq_enable)
    else $error("interrupt did not follow the alarm flag");

  AST_IRQ_OFF: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    wr_evt && !reg_wdata[BIT_ALARM] && !alarm_set |=> !irq_out_pin_oe)
    else $error("interrupt stayed after clearing the flag");

  AST_LEVEL: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    irq_out_pin_oe && !wr_evt && $stable(alarm_irq_enable)
    |-> $past(irq_out_pin_oe) || $rose(alarm_flag)
      || $rose(alarm_irq_enable) || $past(!rst_n))
    else $error("interrupt appeared without a cause");

  AST_NONE_EN: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    min_tgt_ff[7] && hour_tgt_ff[7] && date_tgt_ff[7] && dow_tgt_ff[7]
    |-> !match_all)
    else $error("match with every compare disabled");

  AST_HOLD: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    time_access ##1 time_access |-> !time_inc)
    else $error("time advanced during a serial access");

  AST_PEND: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    hold_ff == TH_PEND && !time_access |=> time_inc)
    else $error("pending tick not serviced after access");

  AST_WR_MIN: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    wr_min |=> min_tgt_ff == $past(reg_wdata))
    else $error("minute target not stored as written");

  AST_HOUR_GAP: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !hour_tgt_ff[6])
    else $error("unused hour target bit is set");

  AST_DATE_GAP: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !date_tgt_ff[6])
    else $error("unused date target bit is set");

  AST_DOW_GAP: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    dow_tgt_ff[6:3] == 4'h0)
    else $error("unused weekday target bits are set");

  AST_WR_DOW: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    wr_dow |=> dow_tgt_ff == ($past(reg_wdata) & MASK_DOW_TGT))
    else $error("weekday target not stored as written");

  AST_UNMAPPED: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    reg_rd && !(sel_min || sel_hour || sel_date || sel_dow || sel_evt)
    |=> reg_rdata == 8'h00)
    else $error("unmapped address did not read as zero");

  AST_RD_STANDS: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  AST_EVT_READ: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    reg_rd && sel_evt |=> reg_rdata == $past(evt_ff))
    else $error("event register read back wrong");

  AST_RUN_INC: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    hold_ff == TH_RUN && !time_access && sec_tick |=> time_inc)
    else $error("free-running tick did not advance time");

  COV_ALARM: cover property (@(posedge clk_sys) disable iff (!rst_n)
    alarm_set ##1 alarm_flag);
  COV_CLEAR: cover property (@(posedge clk_sys) disable iff (!rst_n)
    alarm_flag && wr_evt && !reg_wdata[BIT_ALARM]);
  COV_IRQ: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(irq_out_pin_oe));
  COV_PEND: cover property (@(posedge clk_sys) disable iff (!rst_n)
    hold_ff == TH_PEND ##1 time_inc);
  COV_HOLD: cover property (@(posedge clk_sys) disable iff (!rst_n)
    hold_ff == TH_HOLD && time_access && sec_tick);

endmodule

// File: dv/rtca_host_model.sv
// Host side of the register port: byte reads and writes.
// Assumes strobes are sampled on the rising edge of clk_sys.
module rtca_host_model
  import rtca_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // Released lines show the inverse, so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clk_sys);
    reg_wr = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk_sys);
    reg_rd = 1'h0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask

  // Clear only the alarm: ones on other flags, low bits as read
  task automatic clear_alarm();
    logic [7:0] v;
    rd(ADDR_EVT_FLAG, v);
    wr(ADDR_EVT_FLAG, {5'h1e, v[2:0]});
  endtask
endmodule

// File: dv/testbench.sv
// Self-checking bench for the alarm compare block.
// Assumes the host model owns the register port.
module testbench
  import rtca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, time_inc, alarm_flag, pin_o, pin_oe;
  logic hour_mode_12 = 1'h0;
  logic irq_en = 1'h0;
  logic [6:0] cur_min = 7'h00;
  logic [5:0] cur_hour = 6'h00;
  logic [5:0] cur_date = 6'h01;
  logic [2:0] cur_dow = 3'h0;
  logic [2:0] ctrl_bits;
  logic sec_tick = 1'h0;
  logic time_access = 1'h0;
  logic [3:0] set_p = 4'h0;
  int bad_count = 0;
  int num_checks = 0;
  // Open-drain pin with pull-up
  wire pin = pin_oe ? pin_o : 1'h1;

  always #20 clk_sys = ~clk_sys;

  rtca_alarm dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hour_mode_12(hour_mode_12), .alarm_irq_enable(irq_en),
    .cur_min(cur_min), .cur_hour(cur_hour), .cur_date(cur_date),
    .cur_dow(cur_dow), .sec_tick(sec_tick),
    .time_access(time_access), .time_inc(time_inc),
    .watchdog_expired_set(set_p[3]), .countdown_a_set(set_p[2]),
    .countdown_b_set(set_p[1]), .second_tick_set(set_p[0]),
    .alarm_flag(alarm_flag), .flag_ctrl_bits(ctrl_bits),
    .irq_out_pin_o(pin_o), .irq_out_pin_oe(pin_oe));

  rtca_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Pin level is checked with the flag, since it should follow it
  task automatic flag_is(input logic e);
    chk1("alarm_flag", e, alarm_flag);
    chk1("irq pin", ~(e & irq_en), pin);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      host.rd(ADDR_MIN_TGT + 8'(i), v);
      chk8("target reset", RST_TGT, v);
    end
    host.rd(ADDR_EVT_FLAG, v);
    chk8("event reset", RST_EVT, v);
    chk1("irq pin", 1'h1, pin);
    $display("t_reset done");
  endtask

  task automatic t_masks();
    logic [7:0] m [4];
    m = '{MASK_MIN_TGT, MASK_HOUR_TGT, MASK_DATE_TGT, MASK_DOW_TGT};
    for (int i = 0; i < 4; i++) host.wr(ADDR_MIN_TGT + 8'(i), 8'hff);
    for (int i = 0; i < 4; i++) begin
      host.rd(ADDR_MIN_TGT + 8'(i), v);
      chk8("target bits", m[i], v);
    end
    host.wr(8'h0e, 8'hff);
    host.rd(8'h0e, v);
    chk8("unmapped", 8'h00, v);
    for (int i = 0; i < 4; i++) host.wr(ADDR_MIN_TGT + 8'(i), RST_TGT);
    $display("t_masks done");
  endtask

  task automatic t_minute();
    irq_en = 1'h1;
    cur_min = 7'h10;
    host.wr(ADDR_MIN_TGT, 8'h25);
    cyc(1);
    flag_is(1'h0);
    cur_min = 7'h25;
    cyc(1);
    flag_is(1'h1);
    host.rd(ADDR_EVT_FLAG, v);
    chk8("event bits", 8'h08, v);
    cur_min = 7'h26;
    cyc(4);
    flag_is(1'h1);
    cur_min = 7'h25;
    host.clear_alarm();
    flag_is(1'h0);
    cyc(4);
    flag_is(1'h0);
    cur_min = 7'h24;
    cyc(1);
    cur_min = 7'h25;
    cyc(1);
    flag_is(1'h1);
    irq_en = 1'h0;
    cyc(1);
    flag_is(1'h1);
    host.clear_alarm();
    irq_en = 1'h1;
    host.wr(ADDR_MIN_TGT, RST_TGT);
    $display("t_minute done");
  endtask

  task automatic t_fields();
    hour_mode_12 = 1'h1;
    cur_hour = 6'h12;
    host.wr(ADDR_HOUR_TGT, 8'h32);
    cyc(1);
    flag_is(1'h0);
    cur_hour = 6'h32;
    cyc(1);
    flag_is(1'h1);
    host.clear_alarm();
    hour_mode_12 = 1'h0;
    cur_hour = 6'h22;
    host.wr(ADDR_HOUR_TGT, 8'h23);
    cyc(1);
    flag_is(1'h0);
    cur_hour = 6'h23;
    cyc(1);
    flag_is(1'h1);
    host.clear_alarm();
    host.wr(ADDR_HOUR_TGT, RST_TGT);
    cur_date = 6'h31;
    cur_dow = 3'h5;
    host.wr(ADDR_DOW_TGT, 8'h06);
    host.wr(ADDR_DATE_TGT, 8'h31);
    cyc(1);
    flag_is(1'h0);
    cur_dow = 3'h6;
    cyc(1);
    flag_is(1'h1);
    host.clear_alarm();
    host.wr(ADDR_DOW_TGT, RST_TGT);
    host.wr(ADDR_DATE_TGT, RST_TGT);
    $display("t_fields done");
  endtask

  task automatic t_flags();
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 4; i++) begin
      set_p[3 - i] = 1'h1;
      cyc(1);
      set_p = 4'h0;
      e = e | (8'h80 >> i);
      host.rd(ADDR_EVT_FLAG, v);
      chk8("flag layout", e, v);
    end
    // Ones must not raise the clear alarm bit; low bits take the data
    host.wr(ADDR_EVT_FLAG, 8'hff);
    host.rd(ADDR_EVT_FLAG, v);
    chk8("and write", 8'hf7, v);
    for (int i = 0; i < 3; i++) host.wr(ADDR_EVT_FLAG, 8'h5f);
    host.rd(ADDR_EVT_FLAG, v);
    chk8("rewrite", 8'h57, v);
    chk8("ctrl bits", 8'h07, {5'h00, ctrl_bits});
    host.wr(ADDR_EVT_FLAG, 8'h00);
    $display("t_flags done");
  endtask

  task automatic t_none();
    host.wr(ADDR_MIN_TGT, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      cur_min = 7'h25 ^ 7'(i);
      cur_hour = 6'(i);
      cur_date = 6'(i);
      cur_dow = 3'(i);
      cyc(1);
      flag_is(1'h0);
    end
    // An enabled target with an illegal units digit never matches
    cur_min = 7'h1a;
    host.wr(ADDR_MIN_TGT, 8'h1a);
    cyc(1);
    flag_is(1'h0);
    host.wr(ADDR_MIN_TGT, RST_TGT);
    $display("t_none done");
  endtask

  task automatic t_hold();
    int n;
    sec_tick = 1'h1;
    cyc(1);
    sec_tick = 1'h0;
    chk1("time_inc", 1'h1, time_inc);
    cyc(1);
    chk1("time_inc", 1'h0, time_inc);
    time_access = 1'h1;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      sec_tick = (i == 1 || i == 4) ? 1'h1 : 1'h0;
      cyc(1);
      if (time_inc === 1'h1) n++;
    end
    time_access = 1'h0;
    chk8("held incs", 8'h00, 8'(n));
    n = 0;
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      if (time_inc === 1'h1) n++;
    end
    chk8("released incs", 8'h01, 8'(n));
    $display("t_hold done");
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'h1;
    t_reset();
    t_masks();
    t_minute();
    t_fields();
    t_flags();
    t_none();
    t_hold();
    wrap_up();
  end

  // Guard against a hang
  initial begin
    #2000000;
    bad_count++;
    wrap_up();
  end
endmodule
